/* File: hw/pwg_pkg.sv */
// How it works
// - each generator divides its clock by an 8-bit programmable prescaler first.
// - after the prescaler, each timer selects divide by 1, 2, 4, 8 or 16.
// - two timers per generator, each a 16-bit period down-counter plus duty comparator.
// - eight independent outputs, or four complementary pairs with own dead-zone generators.
// - pair enable 0/1 makes channels 0,1 complementary from timer 0 and dead-zone 0.
// - pairs 2/3, 4/5, 6/7 use timers 2, 4, 6 and dead-zones 1, 2, 3.
// - a channel's interrupt flag sets when its period counter reaches zero.
// - interrupt request only while a flag and its matching enable are both set.
// - period and compare writes are buffered; compare loads at zero, the period at zero in auto mode, on a capture irq, or while run is off.
// - auto-reload mode reloads the period at zero and keeps counting down.
// - one-shot mode stops the counter at zero after one interrupt.
// - output goes high when counter equals compare; compare sets the high width.
// - with capture enabled the channel pin becomes an input, output released.
// - capture uses the same-numbered timer; software sets it up first.
// - rising edge on capture input copies the counter into the rising latch.
// - falling edge on capture input copies the counter into the falling latch.
// - channel 0 rising and falling irq enables are bits 1 and 2 of low control.
// - channel 1 rising and falling irq enables are bits 17 and 18 of low control.
// - channels 2 and 3 use the same scheme in the high capture control register.
// - when a capture channel raises its interrupt, its counter reloads at once.
package pwg_pkg;
  localparam int NCH = 8;
  localparam int AW = 8;
  // register byte offsets
  localparam logic [7:0] OFS_PRESCALE = 8'h00; // 8 bits per generator, generator g at [8g+7:8g]
  localparam logic [7:0] OFS_CLKSEL = 8'h04;   // 3 bits per channel
  localparam logic [7:0] OFS_CTRL = 8'h08;     // pwm_control_reg
  localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h10;
  localparam logic [7:0] OFS_DEADTIME = 8'h14; // 8 bits per pair
  localparam logic [7:0] OFS_CAP_LOW = 8'h18;  // capture_control_low, channels 0,1 and 4,5
  localparam logic [7:0] OFS_CAP_HIGH = 8'h1c; // capture_control_high, channels 2,3 and 6,7
  localparam logic [7:0] OFS_CAP_ENA = 8'h20;  // capture enable per channel
  localparam logic [7:0] OFS_CAP_FLAG = 8'h24; // [7:0] rising, [15:8] falling
  localparam logic [7:0] OFS_CH_BASE = 8'h40;  // 16 bytes per channel
  localparam logic [7:0] OFS_CH_PERIOD = 8'h0;
  localparam logic [7:0] OFS_CH_CMP = 8'h4;
  localparam logic [7:0] OFS_CH_RISE = 8'h8;
  localparam logic [7:0] OFS_CH_FALL = 8'hc;
  // control register fields: per channel run, auto-reload; pair enables
  localparam int CTRL_RUN_LSB = 0;
  localparam int CTRL_AUTO_LSB = 8;
  localparam int CTRL_DZ_LSB = 16;
  // capture control field positions within each 16-bit half
  localparam int CAP_RISE_IE_BIT = 1;
  localparam int CAP_FALL_IE_BIT = 2;
  localparam int CAP_HALF = 16;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_HALF = 16'h0000;
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pwg_bus_req_t;
  typedef struct packed {
    logic [NCH-1:0] out;
    logic [NCH-1:0] oe_n;
  } pwg_pin_t;
endpackage

/* File: hw/pwg_top.sv */
module pwg_top import pwg_pkg::*; #(
  parameter int PRESC_W = 8,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire pwg_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  // pins
  input wire logic [NCH-1:0] pin_in,
  output pwg_pin_t pins,
  // interrupt request
  output logic irq
);
  if (PRESC_W != 8 || CNT_W != 16) begin : g_chk
    $error("pwg_top supports only 8-bit prescale and 16-bit counters");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] presc_cfg_r, clksel_r, ctrl_r, deadtime_r, cap_low_r, cap_high_r;
  logic [NCH-1:0] irq_en_r, irq_flag_r, cap_ena_r, rise_flag_r, fall_flag_r;
  logic [CNT_W-1:0] per_buf_r [NCH];
  logic [CNT_W-1:0] cmp_buf_r [NCH];
  logic [CNT_W-1:0] cmp_act_r [NCH];
  logic [CNT_W-1:0] cnt_r [NCH];
  logic [CNT_W-1:0] rise_lat_r [NCH];
  logic [CNT_W-1:0] fall_lat_r [NCH];
  logic [NCH-1:0] zero_ev, rise_ev, fall_ev, cap_irq_ev, raw_out;
  logic [NCH-1:0] sync1_r, sync2_r, sync3_r;
  logic [NCH-1:0] tick;
  logic [NCH-1:0] wr_ch;
  logic [31:0] rdata_nxt;
  logic [NCH-1:0] rise_ie_v, fall_ie_v;

  // channel window ends below 0xc0; higher addresses must not alias channels
  wire is_ch = bus_req.addr >= OFS_CH_BASE && bus_req.addr < OFS_CH_BASE + 8'(16 * NCH);
  // channel 0 sits at block 4 of the address, so flip the top index bit
  wire [2:0] ch_sel = bus_req.addr[6:4] ^ 3'h4;
  wire [7:0] ch_ofs = {4'h0, bus_req.addr[3:0]};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      presc_cfg_r <= RST_WORD;
      clksel_r <= RST_WORD;
      ctrl_r <= RST_WORD;
      deadtime_r <= RST_WORD;
      cap_low_r <= RST_WORD;
      cap_high_r <= RST_WORD;
      irq_en_r <= '0;
      cap_ena_r <= '0;
    end else if (bus_req.wr && !is_ch) begin
      unique case (bus_req.addr)
        OFS_PRESCALE: presc_cfg_r <= bus_req.wdata;
        OFS_CLKSEL: clksel_r <= bus_req.wdata;
        OFS_CTRL: ctrl_r <= bus_req.wdata;
        OFS_IRQ_EN: irq_en_r <= bus_req.wdata[NCH-1:0];
        OFS_DEADTIME: deadtime_r <= bus_req.wdata;
        OFS_CAP_LOW: cap_low_r <= bus_req.wdata;
        OFS_CAP_HIGH: cap_high_r <= bus_req.wdata;
        OFS_CAP_ENA: cap_ena_r <= bus_req.wdata[NCH-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // capture input synchronisers
  // ----------------------------------------------------------------
  // sync1 feeds only sync2; edges come from sync2 versus sync3
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // ----------------------------------------------------------------
  // prescaler per generator
  // ----------------------------------------------------------------
  logic [PRESC_W-1:0] pcnt_r [4];
  logic [3:0] ptick;
  logic [4:0] div_cnt_r [NCH];
  for (genvar g = 0; g < 4; g++) begin : g_gen
    wire [PRESC_W-1:0] pdiv = presc_cfg_r[8*g +: PRESC_W];
    // >= so lowering the divisor mid-count never waits for a wrap
    assign ptick[g] = (pcnt_r[g] >= pdiv);
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        pcnt_r[g] <= '0;
      end else if (ptick[g]) begin
        pcnt_r[g] <= '0;
      end else begin
        pcnt_r[g] <= pcnt_r[g] + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // channel timers
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire [2:0] sel = clksel_r[3*c +: 3];
    wire run = ctrl_r[CTRL_RUN_LSB + c];
    wire auto = ctrl_r[CTRL_AUTO_LSB + c];
    wire [31:0] cap_reg = (c < 2 || (c >= 4 && c < 6)) ? cap_low_r : cap_high_r;
    wire [4:0] half = (c % 2 == 1) ? 5'd16 : 5'd0;
    wire rise_ie = cap_reg[half + CAP_RISE_IE_BIT];
    wire fall_ie = cap_reg[half + CAP_FALL_IE_BIT];
    assign rise_ie_v[c] = rise_ie;
    assign fall_ie_v[c] = fall_ie;
    logic [4:0] dmask;
    always_comb begin
      unique case (sel)
        3'd1: dmask = 5'h01;
        3'd2: dmask = 5'h03;
        3'd3: dmask = 5'h07;
        3'd4: dmask = 5'h0f;
        default: dmask = 5'h00;
      endcase
    end
    assign tick[c] = ptick[c/2] && ((div_cnt_r[c] & dmask) == dmask);
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        div_cnt_r[c] <= '0;
      end else if (ptick[c/2]) begin
        div_cnt_r[c] <= div_cnt_r[c] + 1'b1;
      end
    end
    assign wr_ch[c] = bus_req.wr && is_ch && ch_sel == 3'(c);
    logic stopped_r;
    // a stop only holds in one-shot mode; switching to auto resumes counting
    wire halt = stopped_r && !auto;
    assign zero_ev[c] = run && tick[c] && cnt_r[c] == '0 && !halt;
    assign rise_ev[c] = cap_ena_r[c] && sync2_r[c] && !sync3_r[c];
    assign fall_ev[c] = cap_ena_r[c] && !sync2_r[c] && sync3_r[c];
    assign cap_irq_ev[c] = (rise_ev[c] && rise_ie) || (fall_ev[c] && fall_ie);
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        per_buf_r[c] <= RST_HALF;
        cmp_buf_r[c] <= RST_HALF;
      end else if (wr_ch[c]) begin
        if (ch_ofs == OFS_CH_PERIOD) per_buf_r[c] <= bus_req.wdata[CNT_W-1:0];
        if (ch_ofs == OFS_CH_CMP) cmp_buf_r[c] <= bus_req.wdata[CNT_W-1:0];
      end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        cnt_r[c] <= RST_HALF;
        cmp_act_r[c] <= RST_HALF;
        stopped_r <= 1'b0;
      end else if (!run) begin
        // preload so a start counts a whole period before its first zero
        cnt_r[c] <= per_buf_r[c];
        stopped_r <= 1'b0;
      end else if (cap_irq_ev[c]) begin
        cnt_r[c] <= per_buf_r[c];
      end else if (tick[c] && !halt) begin
        if (cnt_r[c] == '0) begin
          cmp_act_r[c] <= cmp_buf_r[c];
          if (auto) begin
            cnt_r[c] <= per_buf_r[c];
            stopped_r <= 1'b0;
          end else begin
            stopped_r <= 1'b1;
          end
        end else begin
          cnt_r[c] <= cnt_r[c] - 1'b1;
        end
      end
    end
    // high from compare match down to zero
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        raw_out[c] <= 1'b0;
      end else if (!run || halt) begin
        raw_out[c] <= 1'b0;
      end else if (cnt_r[c] == cmp_act_r[c]) begin
        raw_out[c] <= 1'b1;
      end else if (tick[c] && cnt_r[c] == '0) begin
        raw_out[c] <= 1'b0;
      end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        rise_lat_r[c] <= RST_HALF;
        fall_lat_r[c] <= RST_HALF;
      end else begin
        if (rise_ev[c]) rise_lat_r[c] <= cnt_r[c];
        if (fall_ev[c]) fall_lat_r[c] <= cnt_r[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // dead-zone pairs and pins
  // ----------------------------------------------------------------
  logic [NCH-1:0] pair_out;
  logic [7:0] dz_cnt_r [4][2];
  for (genvar p = 0; p < 4; p++) begin : g_pair
    wire dz_en = ctrl_r[CTRL_DZ_LSB + p];
    wire [7:0] dtime = deadtime_r[8*p +: 8];
    wire [1:0] want = {!raw_out[2*p], raw_out[2*p]};
    for (genvar k = 0; k < 2; k++) begin : g_side
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          dz_cnt_r[p][k] <= '0;
        end else if (!want[k]) begin
          dz_cnt_r[p][k] <= '0;
        end else if (dz_cnt_r[p][k] != dtime) begin
          dz_cnt_r[p][k] <= dz_cnt_r[p][k] + 1'b1;
        end
      end
      assign pair_out[2*p+k] = dz_en ? (want[k] && dz_cnt_r[p][k] == dtime) : raw_out[2*p+k];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pins.out <= '0;
      pins.oe_n <= '1;
    end else begin
      pins.out <= pair_out & ~cap_ena_r;
      pins.oe_n <= cap_ena_r;
    end
  end

  // ----------------------------------------------------------------
  // flags, irq and read-back
  // ----------------------------------------------------------------
  wire clr_flag = bus_req.wr && bus_req.addr == OFS_IRQ_FLAG;
  wire clr_cap = bus_req.wr && bus_req.addr == OFS_CAP_FLAG;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_flag_r <= '0;
      rise_flag_r <= '0;
      fall_flag_r <= '0;
    end else begin
      // set wins over a same-cycle clear
      irq_flag_r <= (irq_flag_r & ~({NCH{clr_flag}} & bus_req.wdata[NCH-1:0])) | zero_ev;
      rise_flag_r <= (rise_flag_r & ~({NCH{clr_cap}} & bus_req.wdata[NCH-1:0])) | rise_ev;
      fall_flag_r <= (fall_flag_r & ~({NCH{clr_cap}} & bus_req.wdata[2*NCH-1:NCH])) | fall_ev;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_flag_r & irq_en_r) || |(rise_flag_r & rise_ie_v) || |(fall_flag_r & fall_ie_v);
    end
  end

  always_comb begin
    rdata_nxt = RST_WORD;
    if (is_ch) begin
      unique case (ch_ofs)
        OFS_CH_PERIOD: rdata_nxt = {16'h0000, per_buf_r[ch_sel]};
        OFS_CH_CMP: rdata_nxt = {16'h0000, cmp_buf_r[ch_sel]};
        OFS_CH_RISE: rdata_nxt = {16'h0000, rise_lat_r[ch_sel]};
        OFS_CH_FALL: rdata_nxt = {16'h0000, fall_lat_r[ch_sel]};
        default: rdata_nxt = RST_WORD;
      endcase
    end else begin
      unique case (bus_req.addr)
        OFS_PRESCALE: rdata_nxt = presc_cfg_r;
        OFS_CLKSEL: rdata_nxt = clksel_r;
        OFS_CTRL: rdata_nxt = ctrl_r;
        OFS_IRQ_EN: rdata_nxt = {24'h000000, irq_en_r};
        OFS_IRQ_FLAG: rdata_nxt = {24'h000000, irq_flag_r};
        OFS_DEADTIME: rdata_nxt = deadtime_r;
        OFS_CAP_LOW: rdata_nxt = cap_low_r;
        OFS_CAP_HIGH: rdata_nxt = cap_high_r;
        OFS_CAP_ENA: rdata_nxt = {24'h000000, cap_ena_r};
        OFS_CAP_FLAG: rdata_nxt = {16'h0000, fall_flag_r, rise_flag_r};
        default: rdata_nxt = RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_rdata <= RST_WORD;
    end else if (bus_req.rd) begin
      bus_rdata <= rdata_nxt;
    end else begin
      bus_rdata <= RST_WORD;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    zero_ev[0] |=> irq_flag_r[0]) else $error("period flag not set");
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    (irq_flag_r & irq_en_r) != '0 |=> irq) else $error("irq not raised");
  rise_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
    rise_ev[0] |=> rise_lat_r[0] == $past(cnt_r[0])) else $error("rising latch wrong");
  fall_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
    fall_ev[0] |=> fall_lat_r[0] == $past(cnt_r[0])) else $error("falling latch wrong");
  cap_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
    cap_ena_r[1] |=> pins.oe_n[1] && !pins.out[1]) else $error("capture pin driven");
  pair_excl_a: assert property (@(posedge clk_sys) disable iff (rst)
    ctrl_r[CTRL_DZ_LSB] |-> !(pair_out[0] && pair_out[1])) else $error("pair overlap");
  buf_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(tick[0] && cnt_r[0] == '0) |=> cmp_act_r[0] == $past(cmp_act_r[0])) else $error("compare loaded early");
  wire run_auto0 = ctrl_r[CTRL_RUN_LSB] && ctrl_r[CTRL_AUTO_LSB];
  reload_a: assert property (@(posedge clk_sys) disable iff (rst)
    run_auto0 && tick[0] && cnt_r[0] == '0 && !cap_irq_ev[0] |=> cnt_r[0] == $past(per_buf_r[0]))
    else $error("no auto reload");
  zero_c: cover property (@(posedge clk_sys) disable iff (rst) zero_ev[0]);
  cap_c: cover property (@(posedge clk_sys) disable iff (rst) rise_ev[2] ##[1:50] fall_ev[2]);
  irq_c: cover property (@(posedge clk_sys) disable iff (rst) irq);
endmodule

/* File: sim/pwg_pin_model.sv */
// ----------------------------------------
// far side of the pins: loads and sources
// ----------------------------------------
module pwg_pin_model import pwg_pkg::*; (
  // pins of the block
  input wire pwg_pin_t pins,
  // level the outside source puts on a released pin
  input wire logic [NCH-1:0] src_lvl,
  // wire level fed back to the block
  output logic [NCH-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // a driven pin shows the block's level, a released one the source's
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pin_in[i] = pins.oe_n[i] ? src_lvl[i] : pins.out[i];
    end
  end
endmodule

/* File: sim/tb.sv */
module tb import pwg_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 20000;
  logic clk_sys;
  logic rst;
  pwg_bus_req_t bus_req;
  logic [31:0] bus_rdata;
  logic [NCH-1:0] pin_in;
  logic [NCH-1:0] src_lvl;
  pwg_pin_t pins;
  logic irq;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;

  pwg_top dut_u (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pin_in(pin_in), .pins(pins), .irq(irq));
  pwg_pin_model pin_u (.pins(pins), .src_lvl(src_lvl), .pin_in(pin_in));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    @(posedge clk_sys);
    d = bus_rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  function automatic logic [7:0] chb(input int c, input logic [7:0] o);
    return OFS_CH_BASE + 8'(c * 16) + o;
  endfunction

  // cycles up to the next rising edge, and high cycles on the way
  task automatic next_rise(input int ch, output int n, output int h);
    logic prev;
    prev = pins.out[ch];
    n = 0;
    h = 0;
    forever begin
      @(posedge clk_sys);
      n++;
      if ((pins.out[ch] === 1'b1 && prev === 1'b0) || n > 5000) break;
      if (pins.out[ch] === 1'b1) h++;
      prev = pins.out[ch];
    end
  endtask

  // first period after a change may be transitional, so skip two
  task automatic meas(input int ch, output int gap, output int hw);
    repeat (3) next_rise(ch, gap, hw);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk({24'h0, pins.oe_n}, 32'hff);
    chk({24'h0, pins.out}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rchk(OFS_CTRL, 32'h0);
    rchk(OFS_IRQ_FLAG, 32'h0);
    wr(8'h30, 32'hffff_ffff);
    rchk(8'h30, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_timebase;
    int g0;
    int h0;
    int g;
    int h;
    wr(OFS_PRESCALE, 32'h0);
    wr(OFS_CLKSEL, 32'h0);
    wr(chb(0, OFS_CH_PERIOD), 32'h5);
    wr(chb(0, OFS_CH_CMP), 32'h2);
    wr(OFS_CTRL, 32'h0101);
    meas(0, g0, h0);
    wr(chb(0, OFS_CH_CMP), 32'h4);
    meas(0, g, h);
    chk(32'(h - h0), 32'h2);
    chk(32'(g), 32'(g0));
    for (int code = 1; code <= 4; code++) begin
      wr(OFS_CLKSEL, 32'(code));
      meas(0, g, h);
      chk(32'(g), 32'(g0 << code));
    end
    wr(OFS_CLKSEL, 32'h0);
    wr(OFS_PRESCALE, 32'h2);
    meas(0, g, h);
    chk(32'(g), 32'(g0 * 3));
    wr(OFS_PRESCALE, 32'h0);
    $display("test timebase done");
  endtask

  task automatic t_irq;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_IRQ_FLAG, 32'hff);
    wr(chb(3, OFS_CH_PERIOD), 32'h3);
    wr(chb(3, OFS_CH_CMP), 32'h1);
    wr(OFS_CTRL, 32'h08);
    repeat (60) @(posedge clk_sys);
    rchk(OFS_IRQ_FLAG, 32'h08);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_EN, 32'h08);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_FLAG, 32'h08);
    repeat (60) @(posedge clk_sys);
    rchk(OFS_IRQ_FLAG, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test irq done");
  endtask

  task automatic t_pair;
    int both;
    int s0;
    int s1;
    int g;
    int h;
    both = 0;
    s0 = 0;
    s1 = 0;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_DEADTIME, 32'h4);
    wr(chb(0, OFS_CH_PERIOD), 32'd20);
    wr(chb(0, OFS_CH_CMP), 32'h8);
    wr(OFS_CTRL, 32'h1_0101);
    repeat (400) begin
      @(posedge clk_sys);
      if (pins.out[0] === 1'b1 && pins.out[1] === 1'b1) both++;
      if (pins.out[0] === 1'b1) s0++;
      if (pins.out[1] === 1'b1) s1++;
    end
    chk(32'(both), 32'h0);
    chk({31'h0, s0 > 0 && s1 > 0}, 32'h1);
    // high width is compare minus dead time; the helper omits the rising sample
    meas(0, g, h);
    chk(32'(g), 32'd21);
    chk(32'(h), 32'd3);
    meas(1, g, h);
    chk(32'(h), 32'd8);
    $display("test pair done");
  endtask

  task automatic t_capture;
    logic [31:0] r;
    logic [31:0] f;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_IRQ_FLAG, 32'hff);
    wr(chb(2, OFS_CH_PERIOD), 32'hffff);
    wr(chb(2, OFS_CH_CMP), 32'h10);
    wr(OFS_CTRL, 32'h0404);
    wr(OFS_CAP_ENA, 32'h04);
    wr(OFS_CAP_FLAG, 32'hffff);
    chk({31'h0, pins.oe_n[2]}, 32'h1);
    src_lvl[2] <= 1'b1;
    repeat (20) @(posedge clk_sys);
    src_lvl[2] <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rchk(OFS_CAP_FLAG, 32'h0404);
    rd(chb(2, OFS_CH_RISE), r);
    rd(chb(2, OFS_CH_FALL), f);
    chk(r - f, 32'd20);
    wr(OFS_CAP_FLAG, 32'h0404);
    rchk(OFS_CAP_FLAG, 32'h0);
    wr(OFS_CAP_LOW, 32'h0006_0006);
    rchk(OFS_CAP_LOW, 32'h0006_0006);
    wr(OFS_CAP_HIGH, 32'h2);
    src_lvl[2] <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    src_lvl[2] <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rd(chb(2, OFS_CH_FALL), f);
    // reload at the rising capture puts the fall near the top of the count
    chk({31'h0, f >= 32'hffe8 && f <= 32'hffef}, 32'h1);
    wr(OFS_CAP_FLAG, 32'hffff);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    $display("test capture done");
  endtask

  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      complete_run;
    end
  end

  initial begin
    bus_req = '0;
    src_lvl = '0;
    rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_timebase;
    t_irq;
    t_pair;
    t_capture;
    complete_run;
  end
endmodule
